// ==== logic/secprot.v ====
`timescale 1ns/1ps
`include "secprot_consts.vh"
// Overview of operation
// - Exit opcode leaves OTP area mode
// - Accept single-line or quad commands
// - Security read answered at any time
// - Read repeats register bytes until deselect
// - Security write only sets lockdown bit one
// - Security write discarded off byte boundary
// - Bit six reports erase failure
// - Bit five reports program failure
// - Bit three shows erase suspended
// - Bit two shows program suspended
// - Bit zero shows factory lock
// - Lockdown freezes flag and OTP area
// - OTP mode blocks main array access
// - Bit seven selects protection scheme
// - Protection select never returns to zero
// - Only one protection scheme active
// - Sector mode starts all dynamic protected
// - Block bits guard array, status lockable
// - Select enables sector lock commands
// - Write-protect low protects all sectors in sector mode outside OTP area mode
// - Dynamic bit, or solid bit without temporary unprotect, blocks sector
// - Gang lock needs enable and byte boundary
module secprot (
  input wire clk,
  input wire rst_n,
  input wire cs_n,
  input wire sclk,
  input wire [3:0] sio_in,
  output reg so_ff,
  output reg so_oe_ff,
  input wire quad_command_mode,
  input wire wp_n,
  input wire factory_lock,
  input wire lockdown_nv,
  input wire prot_sel_nv,
  input wire [7:0] status_reg,
  input wire [`NUM_SECT-1:0] solid_sector_bit,
  input wire temp_unprotect_bit,
  input wire erase_done,
  input wire erase_bad,
  input wire prog_done,
  input wire prog_bad,
  input wire erase_suspend,
  input wire erase_resume,
  input wire prog_suspend,
  input wire prog_resume,
  input wire [3:0] access_sector,
  output reg otp_mode_ff,
  output reg main_array_block_ff,
  output reg sector_protected_ff,
  output reg bp_write_locked_ff,
  output reg sector_cmds_en_ff,
  output reg [7:0] security_reg_ff,
  output reg nv_lockdown_prog_ff,
  output reg nv_prot_sel_prog_ff
);

  // Two-stage synchronisers for pins
  reg [1:0] cs_sync_ff; // Select, idles high
  reg [1:0] clk_sync_ff; // Link clock, idles low
  reg [3:0] sio_s1_ff; // Data lines, first stage
  reg [3:0] sio_s2_ff; // Data lines, second stage
  reg [1:0] wp_sync_ff; // Write-protect pin
  reg sclk_d_ff; // Previous synced clock
  reg cs_sync_d_ff; // Previous synced select
  // Straps caught after reset release
  reg init_ff;

  // Frame state
  reg [7:0] op_ff; // Shift register of opcode
  reg [3:0] bitcnt_ff; // Bits within current byte
  reg opcode_ok_ff; // Full opcode latched
  reg [7:0] opc_ff; // Latched opcode
  reg [7:0] shout_ff; // Output shift
  reg [2:0] outcnt_ff; // Output bit pointer
  reg wel_ff; // Write enable latch

  // Flags below are cleared only by reset or their own strobes
  // Security register bits
  reg lockdown_ff; // Customer lock, one-time
  reg prot_sel_ff; // Scheme select, one-time
  reg efail_ff; // Last erase failed
  reg pfail_ff; // Last program failed
  reg erase_susp_ff; // Erase held
  reg prog_susp_ff; // Program held
  reg fact_ff; // Factory lock copy
  // Volatile per-sector locks; all set after reset
  reg [`NUM_SECT-1:0] dyn_ff;

  // Edges seen through the synchronisers
  // Link clock must stay well below a quarter of the system clock
  wire cs_low = ~cs_sync_ff[1];
  wire rise = clk_sync_ff[1] & ~sclk_d_ff;
  wire fall = ~clk_sync_ff[1] & sclk_d_ff;
  wire cs_rise = cs_sync_ff[1] & ~cs_sync_d_ff;
  wire wp_low = ~wp_sync_ff[1];
  // Deselect only counts on a whole byte
  wire boundary = (bitcnt_ff == 4'h0);
  // Frame closed cleanly with a complete opcode
  wire exec_ok = cs_rise & opcode_ok_ff & boundary;

  // Bit order: select, erase fail, program fail, reserved, suspends, locks
  // Assembled security byte; reserved bit always zero
  function [7:0] pack_sr;
    input w;
    input e;
    input p;
    input es;
    input ps;
    input l;
    input f;
    begin
      pack_sr = {w, e, p, 1'b0, es, ps, l, f};
    end
  endfunction
  wire [7:0] sr_now = pack_sr(prot_sel_ff, efail_ff, pfail_ff, erase_susp_ff, prog_susp_ff,
    lockdown_ff, fact_ff);

  // Synchronise inputs; first stage read only by second
  // Reset levels match idle pins, so no false edge follows reset
  // Costs two cycles of latency on every pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      sio_s1_ff <= 4'h0;
      sio_s2_ff <= 4'h0;
      wp_sync_ff <= 2'h3;
      sclk_d_ff <= 1'b0;
      cs_sync_d_ff <= 1'b1;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], cs_n};
      clk_sync_ff <= {clk_sync_ff[0], sclk};
      sio_s1_ff <= sio_in;
      sio_s2_ff <= sio_s1_ff;
      wp_sync_ff <= {wp_sync_ff[0], wp_n};
      sclk_d_ff <= clk_sync_ff[1];
      cs_sync_d_ff <= cs_sync_ff[1];
    end
  end

  // Command framing; quad mode takes nibbles, else only line 0
  // Upper lines are never looked at in single-line mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      opcode_ok_ff <= 1'b0;
      opc_ff <= 8'h00;
    end else if (!cs_low) begin
      // Idle: restart the byte count for the next frame
      bitcnt_ff <= 4'h0;
      if (cs_rise) begin
        // Frame over: next frame needs a fresh opcode
        opcode_ok_ff <= 1'b0;
      end
    end else if (rise) begin
      if (quad_command_mode) begin
        // Four bits per link clock
        op_ff <= {op_ff[3:0], sio_s2_ff};
        bitcnt_ff <= (bitcnt_ff >= `QUAD_STEP) ? 4'h0 : bitcnt_ff + `QUAD_STEP;
        // Second nibble completes the opcode
        if (!opcode_ok_ff && bitcnt_ff == `QUAD_STEP) begin
          opcode_ok_ff <= 1'b1;
          opc_ff <= {op_ff[3:0], sio_s2_ff};
        end
      end else begin
        // One bit per link clock on line 0
        op_ff <= {op_ff[6:0], sio_s2_ff[0]};
        bitcnt_ff <= (bitcnt_ff == `SER_LAST) ? 4'h0 : bitcnt_ff + 4'h1;
        // Eighth bit completes the opcode
        if (!opcode_ok_ff && bitcnt_ff == `SER_LAST) begin
          opcode_ok_ff <= 1'b1;
          opc_ff <= {op_ff[6:0], sio_s2_ff[0]};
        end
      end
    end
  end

  // Read path: shift register value out continuously
  // Fresh value taken at each byte start, so reads mid-operation see live flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      shout_ff <= 8'h00;
      outcnt_ff <= 3'h0;
    end else if (!cs_low) begin
      // Released line: driver off between frames
      so_oe_ff <= 1'b0;
      // Pointer restarts so each frame begins with bit seven
      outcnt_ff <= 3'h0;
    end else if (opcode_ok_ff && opc_ff == `OP_READ_SEC && fall) begin
      so_oe_ff <= 1'b1;
      if (outcnt_ff == 3'h0) begin
        // Byte start: most significant bit first
        so_ff <= sr_now[7];
        shout_ff <= {sr_now[6:0], 1'b0};
      end else begin
        // Remaining bits of the byte
        so_ff <= shout_ff[7];
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
      // Pointer wraps after eight bits, so the byte repeats
      outcnt_ff <= outcnt_ff + 3'h1;
    end
  end

  // Command execution at deselect, on byte boundary only
  // Commands run after the frame closes, never mid-frame
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ff <= 1'b0;
      wel_ff <= 1'b0;
      otp_mode_ff <= 1'b0;
      lockdown_ff <= 1'b0;
      prot_sel_ff <= 1'b0;
      fact_ff <= 1'b0;
      efail_ff <= 1'b0;
      pfail_ff <= 1'b0;
      erase_susp_ff <= 1'b0;
      prog_susp_ff <= 1'b0;
      dyn_ff <= {`NUM_SECT{1'b1}};
      nv_lockdown_prog_ff <= 1'b0;
      nv_prot_sel_prog_ff <= 1'b0;
    end else begin
      // Programming pulses last one cycle
      nv_lockdown_prog_ff <= 1'b0;
      nv_prot_sel_prog_ff <= 1'b0;
      if (!init_ff) begin
        // Load non-volatile copies once after release
        // A frame closing in this very cycle is lost; hosts wait after reset
        init_ff <= 1'b1;
        lockdown_ff <= lockdown_nv;
        prot_sel_ff <= prot_sel_nv;
        fact_ff <= factory_lock;
      end else if (exec_ok) begin
        // Guarded commands consume the write-enable latch
        case (opc_ff)
          // Latch set; used up by the next guarded command
          `OP_WRITE_ENABLE: wel_ff <= 1'b1;
          // Secured area entry and exit
          `OP_ENTER_OTP: otp_mode_ff <= 1'b1;
          `OP_EXIT_OTP: otp_mode_ff <= 1'b0;
          `OP_WRITE_SEC: begin
            // Needs latch; lockdown is final
            if (wel_ff && !lockdown_ff) begin
              lockdown_ff <= 1'b1;
              nv_lockdown_prog_ff <= 1'b1;
            end
            wel_ff <= 1'b0;
          end
          `OP_PROT_SEL: begin
            // One-time select; nothing ever clears it
            if (wel_ff && !prot_sel_ff) begin
              prot_sel_ff <= 1'b1;
              nv_prot_sel_prog_ff <= 1'b1;
            end
            wel_ff <= 1'b0;
          end
          `OP_GANG_LOCK: begin
            // Only meaningful in sector mode
            if (wel_ff && prot_sel_ff) begin
              dyn_ff <= {`NUM_SECT{1'b1}};
            end
            wel_ff <= 1'b0;
          end
          `OP_GANG_UNLOCK: begin
            // Clears every dynamic lock at once
            if (wel_ff && prot_sel_ff) begin
              dyn_ff <= {`NUM_SECT{1'b0}};
            end
            wel_ff <= 1'b0;
          end
          // Reads and unknown opcodes leave the latch alone
          default: wel_ff <= wel_ff;
        endcase
      end else if (cs_rise && opcode_ok_ff && !boundary) begin
        // Off-boundary write commands are dropped, latch kept
        wel_ff <= wel_ff;
      end
      // Result flags: set wins when events coincide
      // A failure in the same cycle as a success reads as failure
      if (erase_bad) begin
        efail_ff <= 1'b1;
      end else if (erase_done) begin
        efail_ff <= 1'b0;
      end
      if (prog_bad) begin
        pfail_ff <= 1'b1;
      end else if (prog_done) begin
        pfail_ff <= 1'b0;
      end
      // Suspend flags follow the suspend and resume strobes
      if (erase_suspend) begin
        erase_susp_ff <= 1'b1;
      end else if (erase_resume) begin
        erase_susp_ff <= 1'b0;
      end
      if (prog_suspend) begin
        prog_susp_ff <= 1'b1;
      end else if (prog_resume) begin
        prog_susp_ff <= 1'b0;
      end
    end
  end

  // Protection decisions, registered so every output comes from a flop
  // One cycle of lag against the inputs; hosts act on deselect anyway
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_array_block_ff <= 1'b0;
      // Sectors start protected until the straps are known
      sector_protected_ff <= 1'b1;
      bp_write_locked_ff <= 1'b0;
      sector_cmds_en_ff <= 1'b0;
      security_reg_ff <= 8'h00;
    end else begin
      main_array_block_ff <= otp_mode_ff;
      security_reg_ff <= sr_now;
      sector_cmds_en_ff <= prot_sel_ff;
      // Block-bit lock of status only in block mode, pin low as well
      bp_write_locked_ff <= !prot_sel_ff && status_reg[`ST_WRITE_DISABLE] &&
        wp_low;
      // Secured-area mode first, else scheme select decides which protection applies
      if (otp_mode_ff) begin
        // Secured area: writable only before lockdown
        sector_protected_ff <= lockdown_ff;
      end else if (prot_sel_ff) begin
        // Sector scheme: pin low protects all
        sector_protected_ff <= wp_low || dyn_ff[access_sector] ||
          (solid_sector_bit[access_sector] && !temp_unprotect_bit);
      end else begin
        // Block scheme: any set block-protect bit guards the array
        sector_protected_ff <= (status_reg[`BP_HI:`BP_LO] != 4'h0);
      end
    end
  end

endmodule

// ==== logic/secprot_consts.vh ====
`ifndef SECPROT_CONSTS_VH
`define SECPROT_CONSTS_VH
// Opcodes
`define OP_WRITE_ENABLE 8'h06
`define OP_EXIT_OTP 8'hc1
`define OP_ENTER_OTP 8'hb1
`define OP_READ_SEC 8'h2b
`define OP_WRITE_SEC 8'h2f
`define OP_PROT_SEL 8'h68
`define OP_GANG_LOCK 8'h7e
`define OP_GANG_UNLOCK 8'h98
// Security register bit positions
`define SR_PROT_SEL 7
`define SR_EFAIL 6
`define SR_PFAIL 5
`define SR_RSVD 4
`define SR_ERASE_SUSP 3
`define SR_PROG_SUSP 2
`define SR_LOCKDOWN 1
`define SR_FACT 0
// Status register fields
`define ST_WRITE_DISABLE 7
`define BP_HI 5
`define BP_LO 2
// Frame bit counting
`define SER_LAST 4'h7
`define QUAD_STEP 4'h4
// Sector count
`define NUM_SECT 16
`endif

// ==== sim/secprot_assertions.sv ====
`timescale 1ns/1ps
// Watches flag updates and protection outputs at the block's ports
module secprot_assertions (
  input wire clk,
  input wire rst_n,
  input wire wp_n,
  input wire prog_bad,
  input wire erase_bad,
  input wire erase_suspend,
  input wire prog_suspend,
  input wire [7:0] security_reg_ff,
  input wire sector_cmds_en_ff,
  input wire sector_protected_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Failure and suspend events land within a few cycles
  chk_pfail_set: assert property (prog_bad |-> ##[1:4] security_reg_ff[5])
    else $error("program fail flag not set");
  chk_efail_set: assert property (erase_bad |-> ##[1:4] security_reg_ff[6])
    else $error("erase fail flag not set");
  chk_esb_set: assert property (erase_suspend |-> ##[1:4] security_reg_ff[3])
    else $error("erase suspend flag not set");
  chk_psb_set: assert property (prog_suspend |-> ##[1:4] security_reg_ff[2])
    else $error("program suspend flag not set");
  // One-time bits never drop back; reserved bit stays zero
  chk_prot_sel_sticky: assert property (security_reg_ff[7] |=> security_reg_ff[7])
    else $error("protection select returned to zero");
  chk_lock_sticky: assert property (security_reg_ff[1] |=> $stable(security_reg_ff[1]))
    else $error("lockdown flag changed");
  chk_rsvd_zero: assert property (security_reg_ff[4] == 1'b0)
    else $error("reserved bit not zero");
  // Sector commands only in sector mode
  chk_one_scheme: assert property (sector_cmds_en_ff |-> security_reg_ff[7])
    else $error("sector commands enabled in block mode");
  // Pin low outlasting the synchroniser protects everything in sector mode
  chk_wp_all: assert property ((security_reg_ff[7] && !wp_n) [*6] |-> sector_protected_ff)
    else $error("sector writable with write protect low");
endmodule
bind secprot secprot_assertions secprot_assertions_i (.clk, .rst_n, .wp_n, .prog_bad,
  .erase_bad, .erase_suspend, .prog_suspend, .security_reg_ff, .sector_cmds_en_ff,
  .sector_protected_ff);

// ==== sim/spi_host.sv ====
`timescale 1ns/1ps
// Serial host: frames one opcode, optionally clocks reply bytes
module spi_host (
  input wire clk,
  input wire so_ff,
  input wire quad_command_mode,
  output reg cs_n,
  output reg sclk,
  output reg [3:0] sio_in
);
  reg [7:0] rd; // Last eight bits seen on serial out
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio_in = 4'h0;
  end
  // Half of a 160 ns link period, 80 ns
  task half;
    repeat (8) @(negedge clk);
  endtask
  // Clock n units, opcode first; n that is not a whole number of bytes breaks the byte boundary
  task frame(input [7:0] op, input integer n);
    integer i;
    reg [7:0] sh;
    begin
      sh = op;
      cs_n = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        // Upper lines toggle in single mode, device must ignore them
        if (quad_command_mode) sio_in = sh[7:4];
        else sio_in = {~sio_in[3:1], sh[7]};
        sh = quad_command_mode ? sh << 4 : sh << 1;
        half;
        rd = {rd[6:0], so_ff};
        sclk = 1'b1;
        half;
        sclk = 1'b0;
      end
      half;
      cs_n = 1'b1;
      sio_in = ~sio_in; // Released lines do not keep their level
      repeat (64) @(negedge clk);
    end
  endtask
endmodule

// ==== sim/test_flash_security_and_protect_select.sv ====
`timescale 1ns/1ps
`include "secprot_consts.vh"
module test_flash_security_and_protect_select;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg quad = 1'b0;
  reg wp_n = 1'b1;
  reg fact = 1'b1; // Factory-locked part
  reg [3:0] sect = 4'h0;
  reg [7:0] ev = 8'h00; // Event pulses, erase_done down to prog_resume
  integer mismatches = 0;
  integer checks = 0;
  integer cyc = 0;
  integer i;
  wire so_ff;
  wire cs_n;
  wire sclk;
  wire [3:0] sio_in;
  wire otp;
  wire blk;
  wire prot;
  wire en;
  wire [7:0] sr;
  wire oe;
  wire bpl;
  wire nvl;
  wire nvw;
  reg [7:0] stat = 8'h00; // Status register seen by the block
  reg [7:0] nvl_cnt = 8'h00; // Lockdown programming pulses
  reg [7:0] nvw_cnt = 8'h00; // Select programming pulses
  // Event table and the register after each
  localparam [63:0] evs = 64'h1020408008040201;
  localparam [63:0] exp = 64'h230343030b030703;
  spi_host spi_host_i (.clk(clk), .so_ff(so_ff), .quad_command_mode(quad), .cs_n(cs_n),
    .sclk(sclk), .sio_in(sio_in));
  secprot secprot_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
    .so_ff(so_ff), .so_oe_ff(oe), .quad_command_mode(quad), .wp_n(wp_n), .factory_lock(fact),
    .lockdown_nv(1'b0), .prot_sel_nv(1'b0), .status_reg(stat), .solid_sector_bit(16'h0000),
    .temp_unprotect_bit(1'b0), .erase_done(ev[7]), .erase_bad(ev[6]), .prog_done(ev[5]),
    .prog_bad(ev[4]), .erase_suspend(ev[3]), .erase_resume(ev[2]), .prog_suspend(ev[1]),
    .prog_resume(ev[0]), .access_sector(sect), .otp_mode_ff(otp), .main_array_block_ff(blk),
    .sector_protected_ff(prot), .bp_write_locked_ff(bpl), .sector_cmds_en_ff(en),
    .security_reg_ff(sr), .nv_lockdown_prog_ff(nvl), .nv_prot_sel_prog_ff(nvw));
  // Count one-cycle programming pulses where they are settled
  always @(negedge clk) begin
    if (nvl) nvl_cnt <= nvl_cnt + 8'h01;
    if (nvw) nvw_cnt <= nvw_cnt + 8'h01;
  end
  initial begin
    forever #5 clk = ~clk;
  end
  // Compare and count
  task check(input [7:0] seen, input [7:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  // Write enable then the command, single-line mode
  task cmd(input [7:0] op, input integer n);
    begin
      spi_host_i.frame(`OP_WRITE_ENABLE, 8);
      spi_host_i.frame(op, n);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check(sr, 8'h01);
    spi_host_i.frame(`OP_READ_SEC, 24);
    check(spi_host_i.rd, 8'h01);
    check(oe, 1'b0);
    spi_host_i.frame(`OP_WRITE_SEC, 8);
    check(sr, 8'h01);
    cmd(`OP_WRITE_SEC, 9);
    check(sr, 8'h01);
    cmd(`OP_WRITE_SEC, 8);
    check(sr, 8'h03);
    check(nvl_cnt, 8'h01);
    $display("security write tests done");
    for (i = 0; i < 8; i = i + 1) begin
      ev = evs[63-8*i -: 8];
      @(negedge clk);
      ev = 8'h00;
      repeat (6) @(negedge clk);
      check(sr, exp[63-8*i -: 8]);
    end
    // Read while an erase stays suspended
    ev = 8'h08;
    @(negedge clk);
    ev = 8'h00;
    spi_host_i.frame(`OP_READ_SEC, 16);
    check(spi_host_i.rd, 8'h0b);
    $display("flag tests done");
    quad = 1'b1;
    spi_host_i.frame(`OP_ENTER_OTP, 2);
    check({otp, blk}, 2'b11);
    spi_host_i.frame(`OP_EXIT_OTP, 2);
    check({otp, blk}, 2'b00);
    quad = 1'b0;
    $display("secured area tests done");
    // Block scheme: one block-protect bit and write-disable, pin low
    stat = 8'h84;
    wp_n = 1'b0;
    repeat (8) @(negedge clk);
    check({bpl, prot}, 2'b11);
    stat = 8'h00;
    wp_n = 1'b1;
    repeat (8) @(negedge clk);
    check({bpl, prot}, 2'b00);
    $display("block protect tests done");
    cmd(`OP_PROT_SEL, 8);
    check({sr[7], en, prot}, 3'b111);
    check(nvw_cnt, 8'h01);
    cmd(`OP_GANG_UNLOCK, 8);
    check(prot, 1'b0);
    stat = 8'h84;
    wp_n = 1'b0;
    repeat (8) @(negedge clk);
    check({bpl, prot}, 2'b01);
    stat = 8'h00;
    wp_n = 1'b1;
    cmd(`OP_GANG_LOCK, 8);
    check(prot, 1'b1);
    cmd(`OP_WRITE_SEC, 8);
    check(sr, 8'h8b);
    check(nvl_cnt, 8'h01);
    $display("protection select tests done");
    conclude;
  end
endmodule
